/* File: logic/cdopt_axi_slave.sv */
// axi4-lite slave exposing the read-only option register
module cdopt_axi_slave
	import cdopt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// write channels
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read channels
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register content
	input wire logic [7:0] optByte
);
	import cdopt_pkg::*;
	logic awHave_q, wHave_q, bvalid_q, rvalid_q;
	logic [15:0] awAddr_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	function automatic logic isOpt(input logic [15:0] a);
		return a[15:2] == CDOPT_OPTION_BYTE_VIEW_ADDR[15:2];
	endfunction
	// channel handshakes
	assign s_axi_awready = !awHave_q && !bvalid_q;
	assign s_axi_wready = !wHave_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire awDone = awHave_q || awTake;
	wire wDone = wHave_q || wTake;
	wire [15:0] wrAddr = awHave_q ? awAddr_q : s_axi_awaddr;
	wire arHit = isOpt(s_axi_araddr);
	// write path: data discarded, register is read only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			bvalid_q <= 1'b0;
			awAddr_q <= '0;
			bresp_q <= CDOPT_RESP_OKAY;
		end else if (bvalid_q) begin
			if (s_axi_bready) bvalid_q <= 1'b0;
		end else if (awDone && wDone) begin
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			bvalid_q <= 1'b1;
			bresp_q <= isOpt(wrAddr) ? CDOPT_RESP_OKAY : CDOPT_RESP_SLVERR;
		end else begin
			if (awTake) awHave_q <= 1'b1;
			if (awTake) awAddr_q <= s_axi_awaddr;
			if (wTake) wHave_q <= 1'b1;
		end
	end
	// read path
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= CDOPT_RESP_OKAY;
		end else if (rvalid_q) begin
			if (s_axi_rready) rvalid_q <= 1'b0;
		end else if (s_axi_arvalid) begin
			rvalid_q <= 1'b1;
			rdata_q <= arHit ? {24'h000000, optByte} : 32'h00000000;
			rresp_q <= arHit ? CDOPT_RESP_OKAY : CDOPT_RESP_SLVERR;
		end
	end
endmodule

/* File: logic/cdopt_opt_reg.sv */
// holds the loaded option byte, read data from a register
module cdopt_opt_reg
	import cdopt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// load side
	input wire logic loadEn,
	input wire logic [7:0] loadData,
	// read side
	output logic [7:0] optByte
);
	import cdopt_pkg::*;
	logic [7:0] byte_q;
	// only the loader writes; no cpu path exists
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			byte_q <= CDOPT_RESET_VALUE;
		end else if (loadEn) begin
			byte_q <= loadData;
		end
	end
	assign optByte = byte_q;
endmodule

/* File: logic/cdopt_pkg.sv */
package cdopt_pkg;
	// option register, byte address on the register bus
	localparam logic [15:0] CDOPT_OPTION_BYTE_VIEW_ADDR = 16'hf3d8;
	// flash word addresses of the option word, per array size
	localparam logic [16:0] CDOPT_OPT_ADDR_SMALL = 17'h07de0;
	localparam logic [16:0] CDOPT_OPT_ADDR_MID = 17'h0bde0;
	localparam logic [16:0] CDOPT_OPT_ADDR_LARGE = 17'h0fde0;
	// option byte field positions
	localparam int CDOPT_BIT_CLKSRC = 7;
	localparam int CDOPT_BIT_RESP = 2;
	localparam int CDOPT_BIT_LVL_HI = 1;
	localparam int CDOPT_BIT_LVL_LO = 0;
	localparam logic [7:0] CDOPT_RESET_VALUE = 8'h00;
	// axi response codes
	localparam logic [1:0] CDOPT_RESP_OKAY = 2'h0;
	localparam logic [1:0] CDOPT_RESP_SLVERR = 2'h2;
	// flash size selection
	typedef enum logic [1:0] {CDOPT_SIZE_SMALL, CDOPT_SIZE_MID, CDOPT_SIZE_LARGE} cdopt_size_t;
	// settings handed to clock generator and detector
	typedef struct packed {
		logic slowClockSourceSel;
		logic undervoltResponseSel;
		logic undervoltLevelHi;
		logic undervoltLevelLo;
	} cdopt_cfg_t;
	// flash read request
	typedef struct packed {
		logic req;
		logic [16:0] addr;
	} cdopt_flash_req_t;
endpackage

/* File: logic/code_option_loader.sv */
// top: loads option word from flash at reset, drives settings
module code_option_loader
	import cdopt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// strap choosing array size
	input wire cdopt_pkg::cdopt_size_t flashSize,
	// flash read port
	output cdopt_pkg::cdopt_flash_req_t flashReq,
	input wire logic flashAck,
	input wire logic [15:0] flashData,
	// register bus
	input wire logic [15:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [15:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// settings and cpu reset
	output cdopt_pkg::cdopt_cfg_t optCfg,
	output logic cpuRst
);
	import cdopt_pkg::*;
	typedef enum logic [1:0] {CDOPT_ST_IDLE, CDOPT_ST_READ, CDOPT_ST_DONE} cdopt_state_t;
	cdopt_state_t state_q, state_d;
	logic [7:0] optByte;
	logic [16:0] addr_q;
	cdopt_cfg_t cfg_q, cfg_d;
	logic cpuRst_q;
	// strap comes from a pin: two flops before anything reads it
	cdopt_size_t sizeMeta_q, sizeSync_q;
	function automatic logic [16:0] optAddr(input cdopt_size_t s);
		case (s)
			CDOPT_SIZE_SMALL: return CDOPT_OPT_ADDR_SMALL;
			CDOPT_SIZE_MID: return CDOPT_OPT_ADDR_MID;
			default: return CDOPT_OPT_ADDR_LARGE;
		endcase
	endfunction
	// loader sequencing
	always_comb begin
		state_d = state_q;
		case (state_q)
			CDOPT_ST_IDLE: state_d = CDOPT_ST_READ;
			CDOPT_ST_READ: if (flashAck) state_d = CDOPT_ST_DONE;
			default: state_d = CDOPT_ST_DONE;
		endcase
	end
	wire loadEn = (state_q == CDOPT_ST_READ) && flashAck;
	wire loadDone = (state_q == CDOPT_ST_DONE);
	assign flashReq.req = (state_q == CDOPT_ST_READ);
	assign flashReq.addr = addr_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= CDOPT_ST_IDLE;
			addr_q <= '0;
		end else begin
			state_q <= state_d;
			if (state_q == CDOPT_ST_IDLE) addr_q <= optAddr(sizeSync_q);
		end
	end
	// strap synchroniser, free running so it has settled before reset lifts
	always_ff @(posedge clk) begin
		sizeMeta_q <= flashSize;
		sizeSync_q <= sizeMeta_q;
	end
	cdopt_opt_reg uOptReg (
		.clk(clk),
		.sys_rst(sys_rst),
		.loadEn(loadEn),
		.loadData(flashData[7:0]),
		.optByte(optByte)
	);
	// option byte fields, picked apart by position
	assign cfg_d = '{
		slowClockSourceSel: optByte[CDOPT_BIT_CLKSRC],
		undervoltResponseSel: optByte[CDOPT_BIT_RESP],
		undervoltLevelHi: optByte[CDOPT_BIT_LVL_HI],
		undervoltLevelLo: optByte[CDOPT_BIT_LVL_LO]
	};
	// settings held at reset values until load is complete
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_q <= '0;
			cpuRst_q <= 1'b1;
		end else begin
			cpuRst_q <= !loadDone;
			if (loadDone) cfg_q <= cfg_d;
		end
	end
	assign optCfg = cfg_q;
	assign cpuRst = cpuRst_q;
	cdopt_axi_slave uAxi (
		.clk(clk),
		.sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.optByte(optByte)
	);
endmodule

/* File: testbench/cdopt_asserts.sv */
// watches the loader's top ports
module cdopt_asserts
	import cdopt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// flash side and settings
	input wire cdopt_pkg::cdopt_size_t flashSize,
	input wire cdopt_pkg::cdopt_flash_req_t flashReq,
	input wire logic flashAck,
	input wire logic [15:0] flashData,
	input wire cdopt_pkg::cdopt_cfg_t optCfg,
	input wire logic cpuRst,
	// read channel
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp
);
	timeunit 1ns;
	timeprecision 1ns;
	import cdopt_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [7:0] opt_q;
	logic [16:0] addrExp;
	// byte the flash handed over
	always_ff @(posedge clk) if (flashReq.req && flashAck) opt_q <= flashData[7:0];
	// word address expected for the strap
	assign addrExp = flashSize == CDOPT_SIZE_SMALL ? CDOPT_OPT_ADDR_SMALL :
		flashSize == CDOPT_SIZE_MID ? CDOPT_OPT_ADDR_MID : CDOPT_OPT_ADDR_LARGE;
	clk_src_a: assert property (!cpuRst |-> optCfg.slowClockSourceSel == opt_q[7])
		else $error("clock source select wrong");
	resp_sel_a: assert property (!cpuRst |-> optCfg.undervoltResponseSel == opt_q[2])
		else $error("detector response wrong");
	level_sel_a: assert property (!cpuRst |-> optCfg[1:0] == opt_q[1:0])
		else $error("threshold code wrong");
	view_mirror_a: assert property (s_axi_rvalid && !cpuRst && s_axi_rresp == CDOPT_RESP_OKAY
		|-> s_axi_rdata == {24'h0, opt_q}) else $error("register not mirroring option");
	flash_addr_a: assert property (flashReq.req |-> flashReq.addr == addrExp)
		else $error("wrong option word address");
	cfg_hold_a: assert property (cpuRst |-> optCfg == 4'h0)
		else $error("settings moved before load");
	cpu_release_a: assert property (flashReq.req && flashAck |-> ##1 cpuRst ##1 !cpuRst)
		else $error("cpu reset not released on time");
	read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule

/* File: testbench/cdopt_flash_model.sv */
// test data area of the flash, answers lat+1 cycles after the request rises
module cdopt_flash_model
	import cdopt_pkg::*;
(
	// clock and request
	input wire logic clk,
	input wire cdopt_pkg::cdopt_flash_req_t flashReq,
	// programmed content, array size and answer delay
	input wire logic [7:0] optByte,
	input wire cdopt_pkg::cdopt_size_t flashSize,
	input wire logic [3:0] lat,
	// answer
	output logic flashAck = 1'h0,
	output logic [15:0] flashData
);
	timeunit 1ns;
	timeprecision 1ns;
	import cdopt_pkg::*;
	logic [3:0] cnt_q = 4'h0;
	logic [16:0] optAt;
	logic [15:0] word;
	// where the programmer placed the option word for this array size
	assign optAt = flashSize == CDOPT_SIZE_SMALL ? CDOPT_OPT_ADDR_SMALL :
		flashSize == CDOPT_SIZE_MID ? CDOPT_OPT_ADDR_MID : CDOPT_OPT_ADDR_LARGE;
	// option word there; every other byte of the area erased to ones
	assign word = flashReq.addr == optAt ? {8'hff, optByte} : 16'hffff;
	// one pulse per request once the delay is spent
	always @(posedge clk) begin
		cnt_q <= flashReq.req && !flashAck ? cnt_q + 4'h1 : 4'h0;
		flashAck <= flashReq.req && !flashAck && cnt_q == lat;
	end
	// inverted when not answering, so early sampling shows up
	assign flashData = flashAck ? word : ~word;
endmodule

/* File: testbench/tb.sv */
module tb
	import cdopt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, sys_rst = 1'h1, flashAck, cpuRst;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0, flashData;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb = 4'hf, lat = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] optByte = 8'h0;
	cdopt_size_t flashSize = CDOPT_SIZE_SMALL;
	cdopt_flash_req_t flashReq;
	cdopt_cfg_t optCfg;
	int mismatches = 0, n_compared = 0, cycles = 0;
	localparam logic [15:0] VA = CDOPT_OPTION_BYTE_VIEW_ADDR;
	code_option_loader uut (
		.clk(clk), .sys_rst(sys_rst), .flashSize(flashSize),
		.flashReq(flashReq), .flashAck(flashAck), .flashData(flashData),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.optCfg(optCfg), .cpuRst(cpuRst)
	);
	cdopt_flash_model flash (
		.clk(clk), .flashReq(flashReq), .optByte(optByte), .flashSize(flashSize),
		.lat(lat), .flashAck(flashAck), .flashData(flashData)
	);
	always #50 clk = ~clk;
	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask
	task end_of_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task rd(input logic [15:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task wr(input logic [15:0] a);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		s_axi_awaddr <= a;
		s_axi_wdata <= 32'hffffffff;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready === 1'h1) ta = 1'h1;
			if (s_axi_wready === 1'h1) tw = 1'h1;
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
		end while (!(ta && tw));
		do @(posedge clk); while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	// reset with a strap and content, then check settings and register
	task t_load(input logic [7:0] o, input cdopt_size_t s, input logic [3:0] l);
		@(posedge clk);
		optByte <= o;
		flashSize <= s;
		lat <= l;
		sys_rst <= 1'h1;
		repeat (20) @(posedge clk);
		sys_rst <= 1'h0;
		@(posedge clk);
		chk("cpuRst held", 32'h1, 32'(cpuRst));
		chk("optCfg held", 32'h0, 32'(optCfg));
		for (int i = 0; i < 40 && cpuRst !== 1'h0; i++) @(posedge clk);
		chk("cpuRst", 32'h0, 32'(cpuRst));
		chk("optCfg", 32'({o[7], o[2:0]}), 32'(optCfg));
		rd(VA);
		chk("view", {24'h0, o}, d);
		$display("load %h finished", o);
	endtask
	// writes are answered but never change the register
	task t_regs(input logic [7:0] o);
		wr(VA);
		chk("bresp", 32'(CDOPT_RESP_OKAY), 32'(r));
		rd(VA);
		chk("view kept", {24'h0, o}, d);
		wr(16'h0000);
		chk("bresp unmapped", 32'(CDOPT_RESP_SLVERR), 32'(r));
		rd(16'h0004);
		chk("rresp unmapped", 32'(CDOPT_RESP_SLVERR), 32'(r));
		chk("rdata unmapped", 32'h0, d);
		$display("register access finished");
	endtask
	initial begin
		t_load(8'h80, CDOPT_SIZE_SMALL, 4'h0);
		t_load(8'h05, CDOPT_SIZE_MID, 4'h3);
		t_load(8'h7a, CDOPT_SIZE_LARGE, 4'h7);
		t_regs(8'h7a);
		t_load(8'hff, CDOPT_SIZE_LARGE, 4'h1);
		end_of_test();
	end
endmodule
bind code_option_loader cdopt_asserts chk (
	.clk(clk), .sys_rst(sys_rst), .flashSize(flashSize), .flashReq(flashReq),
	.flashAck(flashAck), .flashData(flashData), .optCfg(optCfg), .cpuRst(cpuRst),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp)
);
